// [inc/bmr_pkg.sv]
// constants, field layouts and carrier types of the boot mode / reset pin
// controller; assumes a 32-bit APB slave port with byte addressing
package bmr_pkg;

   // ****************************************************
   // register map
   // ****************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;

   localparam int CTRL_W = 4;
   localparam int CTRL_BUS16 = 0;
   localparam int CTRL_NMI_BOTH = 1;
   localparam int CTRL_P30_PULL = 2;
   localparam int CTRL_P30_OUT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h4;

   localparam int STAT_BOOT = 0;
   localparam int STAT_MODE_OK = 1;
   localparam int STAT_EXT_ACCESS = 2;
   localparam int STAT_WIDTH_PIN = 3;
   localparam int STAT_BUS16 = 4;
   localparam int STAT_FAULT = 5;

   // ****************************************************
   // timing
   // ****************************************************
   localparam int CLK_DIV_DEFAULT = 4;
   localparam int DIV_CNT_W = 8;

   // ****************************************************
   // types
   // ****************************************************
   typedef enum logic [1:0] {
      MODE_NONE,
      MODE_CHIP,
      MODE_BOOT,
      MODE_FAULT
   } bmr_mode_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } bmr_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } bmr_apb_rsp_t;

   typedef struct packed {
      bmr_mode_t mode;
      logic [CTRL_W-1:0] ctrl;
      logic [DIV_CNT_W-1:0] divCnt;
      logic clkOut;
      logic clkDrive;
      logic clkP57Pull;
      logic p30Pull;
      logic rstPull;
      logic nmiPrev;
      logic nmiReq;
      logic bus16;
      logic runFlash;
      logic runBootRom;
      logic cpuHold;
      bmr_apb_rsp_t rsp;
   } bmr_state_t;

   localparam bmr_state_t ST_RESET = '{
      mode: MODE_NONE,
      ctrl: CTRL_RESET,
      divCnt: '0,
      clkOut: 1'b0,
      clkDrive: 1'b0,
      clkP57Pull: 1'b1,
      p30Pull: 1'b1,
      rstPull: 1'b1,
      nmiPrev: 1'b1,
      nmiReq: 1'b0,
      bus16: 1'b1,
      runFlash: 1'b0,
      runBootRom: 1'b0,
      cpuHold: 1'b1,
      rsp: '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0}
   };

endpackage

// [verilog/bmr_boot_ctrl.sv]
// boot mode selection, clock output divider, pin pull-up control and
// non-maskable interrupt edge detection; assumes all pins but the async reset pin are synchronous
// to clk_sys and that software reaches the registers over APB
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module bmr_boot_ctrl #(
   parameter int CLK_DIV = bmr_pkg::CLK_DIV_DEFAULT // oscillator divide
) (
   input wire logic clk_sys, // oscillator clock
   input wire logic rst, // reset pin, active high, async
   input wire bmr_pkg::bmr_apb_req_t apbReq, // apb request
   output var bmr_pkg::bmr_apb_rsp_t apbRsp, // apb answer
   input wire logic extAccessPin, // ext_access_pin level
   input wire logic bootPin, // boot select pin level
   input wire logic busWidthPin, // bus_width_select_pin level
   input wire logic nmiPin, // non-maskable interrupt pin
   output logic clkOutPin, // divided clock output
   output logic clkOutDrive, // clock output driver enabled
   output logic clkOutPullUp, // pull-up on clock output pin
   output logic port5Bit7PullUp, // pull-up on port5_bit7
   output logic port3Bit0PullUp, // pull-up on port3_bit0
   output logic port3Bit0OutMode, // port3_bit0 set as output
   output logic resetPinPullUp, // pull-up on reset pin
   output logic nmiRequest, // one-cycle nmi pulse
   output logic extBus16, // external data bus is 16 bits
   output logic runFlash, // cpu starts from internal flash
   output logic runBootRom, // cpu starts boot rom rewrite
   output logic cpuResetHold // cpu held in reset
);
   import bmr_pkg::*;

   localparam int HALF = CLK_DIV / 2;
   localparam logic [DIV_CNT_W-1:0] HALF_LAST = DIV_CNT_W'(HALF - 1);

   // ****************************************************
   // elaboration checks
   // ****************************************************
   // the divider toggles every half period, so the ratio must be even
   if (CLK_DIV < 2 || (CLK_DIV % 2) != 0 ||
       HALF > (1 << DIV_CNT_W)) begin : g_bad_div
      $error("CLK_DIV must be even, at least 2 and fit the counter");
   end

   bmr_state_t st;
   bmr_state_t nx;
   logic apbAccess;
   logic edgeSeen;

   function automatic logic [31:0] statusWord(input bmr_state_t s,
                                              input logic ea,
                                              input logic wp);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[STAT_BOOT] = (s.mode == MODE_BOOT);
      w[STAT_MODE_OK] = (s.mode == MODE_CHIP) || (s.mode == MODE_BOOT);
      w[STAT_EXT_ACCESS] = ea;
      w[STAT_WIDTH_PIN] = wp;
      w[STAT_BUS16] = s.bus16;
      w[STAT_FAULT] = (s.mode == MODE_FAULT);
      return w;
   endfunction

   // ****************************************************
   // next state
   // ****************************************************
   // one wait state: the answer is registered, so pready rises one cycle
   // into the access phase and drops again the cycle after
   assign apbAccess = apbReq.psel && apbReq.penable && !st.rsp.pready;

   always_comb begin
      nx = st;

      case (st.mode)
         MODE_NONE: begin
            if (extAccessPin) begin
               nx.mode = bootPin ? MODE_CHIP : MODE_BOOT;
               nx.runFlash = bootPin;
               nx.runBootRom = !bootPin;
               nx.cpuHold = 1'b0;
            end else begin
               // external access low breaks the board contract: cpu stays
               // held so no code runs from an undefined source
               nx.mode = MODE_FAULT;
            end
         end
         MODE_CHIP, MODE_BOOT, MODE_FAULT: begin
            nx.mode = st.mode;
         end
         default: begin
            nx.mode = MODE_FAULT;
         end
      endcase

      nx.clkDrive = 1'b1;
      if (st.divCnt == HALF_LAST) begin
         nx.divCnt = '0;
         nx.clkOut = !st.clkOut;
      end else begin
         nx.divCnt = st.divCnt + DIV_CNT_W'(1);
      end

      nx.clkP57Pull = 1'b0;

      nx.p30Pull = st.ctrl[CTRL_P30_PULL] && !st.ctrl[CTRL_P30_OUT];

      nx.rstPull = 1'b1;

      nx.nmiPrev = nmiPin;
      nx.nmiReq = st.ctrl[CTRL_NMI_BOTH] ? (nmiPin != st.nmiPrev)
                                         : (st.nmiPrev && !nmiPin);

      // bus width source
      // a low width pin forces the 16-bit bus; high leaves it to software
      nx.bus16 = busWidthPin ? st.ctrl[CTRL_BUS16] : 1'b1;

      // apb slave
      nx.rsp.pready = apbAccess;
      nx.rsp.pslverr = 1'b0;
      if (apbAccess) begin
         case (apbReq.paddr)
            OFF_CTRL: begin
               if (apbReq.pwrite) begin
                  nx.ctrl = apbReq.pwdata[CTRL_W-1:0];
               end
               nx.rsp.prdata = {{(32 - CTRL_W){1'b0}}, st.ctrl};
            end
            OFF_STATUS: begin
               // writes to the status word are ignored without error
               nx.rsp.prdata = statusWord(st, extAccessPin, busWidthPin);
            end
            default: begin
               nx.rsp.prdata = 32'h0000_0000;
               nx.rsp.pslverr = 1'b1;
            end
         endcase
      end
   end

   // ****************************************************
   // state register
   // ****************************************************
   // whole-block reset
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= ST_RESET;
      end else begin
         st <= nx;
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   assign apbRsp = st.rsp;
   assign clkOutPin = st.clkOut;
   assign clkOutDrive = st.clkDrive;
   assign clkOutPullUp = st.clkP57Pull;
   assign port5Bit7PullUp = st.clkP57Pull;
   assign port3Bit0PullUp = st.p30Pull;
   assign port3Bit0OutMode = st.ctrl[CTRL_P30_OUT];
   assign resetPinPullUp = st.rstPull;
   assign nmiRequest = st.nmiReq;
   assign extBus16 = st.bus16;
   assign runFlash = st.runFlash;
   assign runBootRom = st.runBootRom;
   assign cpuResetHold = st.cpuHold;

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   assign edgeSeen = st.nmiPrev != nmiPin;

   sequence sq_first_cycle;
      st.mode == MODE_NONE;
   endsequence

   sequence sq_apb_access;
      apbReq.psel && apbReq.penable && !st.rsp.pready;
   endsequence

   sequence sq_apb_answer;
      st.rsp.pready ##1 !st.rsp.pready;
   endsequence

   mode_chip_sel_a: assert property (
      sq_first_cycle and (extAccessPin && bootPin) |=>
         st.mode == MODE_CHIP)
      else $error("boot pin high did not select single-chip mode");

   mode_boot_sel_a: assert property (
      sq_first_cycle and (extAccessPin && !bootPin) |=>
         st.mode == MODE_BOOT)
      else $error("boot pin low did not select single-boot mode");

   flash_start_a: assert property (
      st.mode == MODE_CHIP |-> st.runFlash && !st.runBootRom && !st.cpuHold)
      else $error("single-chip mode is not running from flash");

   bootrom_start_a: assert property (
      st.mode == MODE_BOOT |-> st.runBootRom && !st.runFlash && !st.cpuHold)
      else $error("single-boot mode is not running the boot rom");

   clk_quarter_a: assert property (
      (CLK_DIV == 4) && $rose(st.clkOut) |=>
         st.clkOut ##1 !st.clkOut ##1 !st.clkOut ##1 st.clkOut)
      else $error("clock output is not a quarter of the oscillator");

   reset_pull_off_a: assert property (
      st.mode != MODE_NONE |-> !st.clkP57Pull && !$rose(st.clkP57Pull))
      else $error("clock or port5_bit7 pull-up kept after reset");

   p30_pull_a: assert property (
      st.clkDrive && st.ctrl[CTRL_P30_OUT] |=> !st.p30Pull)
      else $error("port3_bit0 pulled up while set as output");

   nmi_fall_a: assert property (
      st.nmiPrev && !nmiPin |=> st.nmiReq)
      else $error("falling nmi edge gave no request");

   nmi_rise_a: assert property (
      edgeSeen && nmiPin |=> st.nmiReq == $past(st.ctrl[CTRL_NMI_BOTH]))
      else $error("rising nmi edge handled against the edge select");

   bus_width_a: assert property (
      busWidthPin ##1 busWidthPin |->
         st.bus16 == $past(st.ctrl[CTRL_BUS16]))
      else $error("bus width not taken from control register");

   reset_pin_pull_a: assert property (
      st.rstPull)
      else $error("reset pin pull-up removed");

   mode_hold_a: assert property (
      st.mode != MODE_NONE |=> $stable(st.mode))
      else $error("operating mode changed before the next reset");

   apb_answer_a: assert property (
      sq_apb_access |=> sq_apb_answer)
      else $error("apb answer not given one cycle into access");

endmodule

`default_nettype wire

// [test/bmr_board_model.sv]
// board side of the mode, width and nmi pins of the reset controller
// assumes commands change right after a rising clk_sys edge
`timescale 1ns/1ps
`default_nettype none

module bmr_board_model (
   input wire logic bootSel, // wanted boot pin level
   input wire logic nmiLevel, // wanted nmi pin level
   output logic extAccessPin, // ext_access_pin level
   output logic busWidthPin, // bus_width_select_pin level
   output logic bootPin, // boot select pin level
   output logic nmiPin // nmi pin level
);
   assign extAccessPin = 1'b1;
   assign busWidthPin = 1'b1;
   // no pull on boot or nmi, so the model always drives them
   assign bootPin = bootSel;
   assign nmiPin = nmiLevel;
endmodule

`default_nettype wire

// [test/boot_mode_reset_pin_control_tb.sv]
// self-checking bench of the boot mode and reset pin controller
// assumes one clock, apb master driven by this bench
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin \
   $display("ERROR %0t: got %h want %h", $time, (a), (e)); \
   errTotal++; end end

module boot_mode_reset_pin_control_tb;
   import bmr_pkg::*;
   // reset stands from time zero so that no clock edge meets unknown state
   logic clk_sys = 1'b0, rst = 1'b1, bootSel = 1'b1, nmiLevel = 1'b1;
   logic extAccessPin, busWidthPin, bootPin, nmiPin;
   logic clkOutPin, clkOutDrive, clkOutPullUp, port5Bit7PullUp;
   logic port3Bit0PullUp, port3Bit0OutMode, resetPinPullUp, nmiRequest;
   logic extBus16, runFlash, runBootRom, cpuResetHold, err;
   logic [31:0] rd;
   logic [7:0] s;
   bmr_apb_req_t apbReq = '0;
   bmr_apb_rsp_t apbRsp;
   int errTotal = 0, cmpCount = 0, cycles = 0;

   always #4 clk_sys = ~clk_sys;

   bmr_board_model i_board (.bootSel, .nmiLevel, .extAccessPin,
      .busWidthPin, .bootPin, .nmiPin);

   bmr_boot_ctrl #(.CLK_DIV(4)) i_dut (.clk_sys, .rst, .apbReq, .apbRsp,
      .extAccessPin, .bootPin, .busWidthPin, .nmiPin, .clkOutPin,
      .clkOutDrive, .clkOutPullUp, .port5Bit7PullUp, .port3Bit0PullUp,
      .port3Bit0OutMode, .resetPinPullUp, .nmiRequest, .extBus16,
      .runFlash, .runBootRom, .cpuResetHold);

   // ****************************************************
   // tasks
   // ****************************************************
   task automatic endOfTest();
      if (errTotal == 0 && cmpCount > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clk_sys);
      apbReq.psel <= 1'b1;
      apbReq.penable <= 1'b0;
      apbReq.pwrite <= wr;
      apbReq.paddr <= a;
      apbReq.pwdata <= wd;
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (apbRsp.pready !== 1'b1 && k < 20);
      if (k >= 20) errTotal++;
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      #1;
   endtask

   task automatic doReset(input logic boot);
      @(posedge clk_sys);
      rst <= 1'b1;
      bootSel <= boot;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK({clkOutPullUp, port5Bit7PullUp, clkOutDrive}, 3'h6)
      `CHK({port3Bit0PullUp, resetPinPullUp}, 2'h3)
      `CHK({runFlash, runBootRom, cpuResetHold}, 3'h1)
      @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK({runFlash, runBootRom}, {boot, ~boot})
      `CHK(cpuResetHold, 1'b0)
      `CHK({clkOutPullUp, port5Bit7PullUp}, 2'h0)
   endtask

   task automatic nmiEdge(input logic lvl, input int exp);
      int n;
      n = 0;
      @(posedge clk_sys);
      nmiLevel <= lvl;
      repeat (4) begin
         @(posedge clk_sys);
         #1;
         if (nmiRequest === 1'b1) n++;
      end
      `CHK(n, exp)
   endtask

   // ****************************************************
   // timeout
   // ****************************************************
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         errTotal++;
         endOfTest();
      end
   end

   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      doReset(1'b1);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         #1;
         s[i] = clkOutPin;
      end
      for (int i = 2; i < 8; i++) `CHK(s[i], ~s[i-2])
      `CHK(clkOutDrive, 1'b1)
      apb(1'b0, OFF_CTRL, 32'h0);
      `CHK(rd, 32'h0000_0004)
      apb(1'b1, OFF_CTRL, 32'h0000_0008);
      `CHK({port3Bit0OutMode, port3Bit0PullUp}, 2'h2)
      apb(1'b1, OFF_CTRL, 32'h0000_0004);
      `CHK({port3Bit0OutMode, port3Bit0PullUp}, 2'h1)
      apb(1'b1, OFF_CTRL, 32'h0000_0000);
      `CHK(port3Bit0PullUp, 1'b0)
      `CHK(resetPinPullUp, 1'b1)
      apb(1'b1, OFF_CTRL, 32'h0000_0001);
      `CHK(extBus16, 1'b1)
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK({rd[31:6], rd[5:1], err}, {26'h0, 5'h0F, 1'b0})
      // unmapped word answers with an error and no data
      apb(1'b0, 8'h08, 32'h0);
      `CHK({rd, err}, {32'h0, 1'b1})
      nmiEdge(1'b0, 1);
      nmiEdge(1'b1, 0);
      apb(1'b1, OFF_CTRL, 32'h0000_0002);
      nmiEdge(1'b0, 1);
      nmiEdge(1'b1, 1);
      @(posedge clk_sys);
      bootSel <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK({runFlash, runBootRom}, 2'h2)
      doReset(1'b0);
      apb(1'b0, OFF_CTRL, 32'h0);
      `CHK(rd, 32'h0000_0004)
      // boot mode, valid, pins high, control reset leaves 8-bit bus
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK({rd, err}, {32'h0000_000F, 1'b0})
      endOfTest();
   end
endmodule

`default_nettype wire
